// file: rtl/cspa_regs.svh
// Register offsets, field positions, reset values and fault codes of the cam switch point block
`ifndef CSPA_REGS_SVH
`define CSPA_REGS_SVH

// Register byte offsets on the APB
`define CSPA_OFF_CTRL     8'h00
`define CSPA_OFF_SEL      8'h04
`define CSPA_OFF_WPOS_LO  8'h08
`define CSPA_OFF_WPOS_HI  8'h0C
`define CSPA_OFF_WMODE    8'h10
`define CSPA_OFF_STAT     8'h14
`define CSPA_OFF_FAULT    8'h18
`define CSPA_OFF_RPOS_LO  8'h1C
`define CSPA_OFF_RPOS_HI  8'h20
`define CSPA_OFF_RINFO    8'h24
`define CSPA_OFF_ACTIVE   8'h28

// Control register bit positions
`define CSPA_CTRL_RD      0
`define CSPA_CTRL_WR      1
`define CSPA_CTRL_OP_LSB  2
`define CSPA_CTRL_FWD_GIV 4
`define CSPA_CTRL_REV_GIV 5

// Select register field positions
`define CSPA_SEL_PROF_LSB 0
`define CSPA_SEL_PT_LSB   8

// Write operations carried in the control register
`define CSPA_WOP_WRITE    2'h0
`define CSPA_WOP_ADD      2'h1
`define CSPA_WOP_DEL      2'h2

// Reset values
`define CSPA_CTRL_RST     6'h00
`define CSPA_ACTIVE_RST   8'h00

// Fault codes
`define CSPA_FAULT_NONE   16'h0000
`define CSPA_FAULT_PROF   16'h0001
`define CSPA_FAULT_POINT  16'h0002
`define CSPA_FAULT_ABSENT 16'h0003
`define CSPA_FAULT_EXISTS 16'h0004
`define CSPA_FAULT_OP     16'h0005

`endif

// file: rtl/cspa_pkg.sv
// Types shared by the cam switch point block
package cspa_pkg;

	// Pass action code, same for both directions
	typedef enum logic [1:0] {
		ACT_HOLD   = 2'h0,
		ACT_SET    = 2'h1,
		ACT_CLEAR  = 2'h2,
		ACT_TOGGLE = 2'h3
	} cspa_act_t;

	// Pass scan sequencer
	typedef enum logic {SC_IDLE, SC_RUN} cspa_scan_t;

	// One stored switch point setting
	typedef struct packed {
		logic [1:0]  fwd;
		logic [1:0]  rev;
		logic [63:0] pos;
	} cspa_point_t;

endpackage

// file: rtl/cspa_fkey.sv
// Maps a double precision float to an unsigned key with the same ordering
`timescale 1ns/100ps

module cspa_fkey (
	input  wire logic [63:0] fval,
	output logic      [63:0] key
);

	////////////////////////////////////////////////////////////////////////////
	// Negative values invert fully, positive ones flip the sign only;
	// unsigned compare of keys then orders like the floats (NaN not handled)
	always_comb begin
		key = fval[63] ? ~fval : {1'b1, fval[62:0]};
	end

endmodule // cspa_fkey

// file: rtl/cspa_top.sv
// Cam switch point table with point read/write commands and pass detection
`timescale 1ns/100ps
`include "cspa_regs.svh"

// Behaviour
// - Read returns position and both pass modes
// - Read position given as float value
// - Forward code: 0 hold,1 set,2 clear,3 toggle
// - Forward crossing with hold keeps state
// - Forward crossing set drives true, clear false
// - Forward crossing toggle inverts state
// - Reverse crossing with hold keeps state
// - Reverse crossing set true, clear false
// - Reverse crossing toggle inverts state
// - Write can modify, add or delete point
// - Write starts on rising start, captures inputs
// - Write stores new float position
// - Write raises done on success
// - Read valid while returned info valid
// - Failure raises error with 16-bit code
// - Read starts on rising start, captures indices
module cspa_top
	import cspa_pkg::*;
#(
	parameter int NPROF = 32,  // cam profiles
	parameter int NPTS  = 8    // switch points per profile
) (
	input  wire logic            ref_clk,
	input  wire logic            rst_b,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [7:0]      paddr,
	input  wire logic [31:0]     pwdata,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic [63:0]     master_axis_position,
	input  wire logic            master_pos_valid,
	output logic                 master_pos_ready,
	output logic      [NPTS-1:0] active_point_states
);

	localparam int TOT = NPROF * NPTS;
	localparam int IW  = $clog2(TOT);
	localparam int PW  = (NPTS > 1) ? $clog2(NPTS) : 1;

	// Whole block state except the settings memory pmem
	typedef struct packed {
		logic [5:0]     ctrl;      // start bits, op, mode-given flags
		logic           rd_prev;   // start level one cycle back
		logic           wr_prev;
		logic [31:0]    sel;       // profile and point selection
		logic [63:0]    wpos;      // position to write
		logic [3:0]     wmode;     // reverse[3:2], forward[1:0]
		logic [7:0]     active;    // profile followed by pass detection
		logic [31:0]    prdata;
		logic           rd_busy;
		logic           rd_valid;
		logic           rd_err;
		logic [15:0]    rd_fault;
		logic           wr_busy;
		logic           wr_done;
		logic           wr_err;
		logic [15:0]    wr_fault;
		logic [7:0]     rd_prof;
		logic [15:0]    rd_pt;
		logic [7:0]     wr_prof;
		logic [15:0]    wr_pt;
		logic [63:0]    wr_pos;
		logic [1:0]     wr_fwd;
		logic [1:0]     wr_rev;
		logic [1:0]     wr_op;
		logic [63:0]    rd_pos;
		logic [1:0]     rd_fwd;
		logic [1:0]     rd_rev;
		logic           rd_state;
		cspa_scan_t     sc;
		logic [PW-1:0]  sc_idx;
		logic [IW-1:0]  sc_base;
		logic [63:0]    prev_key;  // key of the previous axis sample
		logic [63:0]    cur_key;   // key of the newest axis sample
		logic           have_prev;
		logic [TOT-1:0] exists;    // point present in its profile
		logic [TOT-1:0] pstate;    // point on/off state
	} cspa_st_t;

	cspa_st_t     s_r;
	cspa_st_t     s_nxt;
	cspa_point_t  pmem [TOT];      // point settings, no reset needed
	logic         mem_we;
	logic [IW-1:0] mem_wa;
	cspa_point_t  mem_wd;
	logic [63:0]  new_key;         // key of the incoming sample
	logic [63:0]  pt_key;          // key of the point being scanned
	logic [IW-1:0] sc_pi;          // flat index of scanned point
	logic [IW-1:0] rd_fi;
	logic [IW-1:0] wr_fi;
	logic         rd_go;
	logic         wr_go;
	logic         rd_ok;
	logic         wr_ok;
	logic         sc_on;
	logic         fhit;
	logic         rhit;
	logic [1:0]   sc_act;
	logic         del_now;         // delete takes effect this cycle
	logic         mapped;

	// Flat point index from profile and point number
	function automatic logic [IW-1:0] flat(input logic [7:0] pr, input logic [15:0] pt);
		flat = IW'(int'(pr) * NPTS + int'(pt));
	endfunction

	// Next point state for an action code
	function automatic logic apply_act(input logic [1:0] act, input logic old);
		unique case (act)
			ACT_HOLD:   apply_act = old;
			ACT_SET:    apply_act = 1'b1;
			ACT_CLEAR:  apply_act = 1'b0;
			ACT_TOGGLE: apply_act = ~old;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Order keys for the incoming sample and the scanned point
	cspa_fkey u_key_new (
		.fval (master_axis_position),
		.key  (new_key)
	);

	cspa_fkey u_key_pt (
		.fval (pmem[sc_pi].pos),
		.key  (pt_key)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt   = s_r;
		mem_we  = 1'b0;
		mem_wa  = '0;
		mem_wd  = '0;
		del_now = 1'b0;
		sc_pi   = s_r.sc_base + IW'(s_r.sc_idx);
		rd_fi   = flat(s_r.rd_prof, s_r.rd_pt);
		wr_fi   = flat(s_r.wr_prof, s_r.wr_pt);
		mapped  = paddr inside {`CSPA_OFF_CTRL, `CSPA_OFF_SEL, `CSPA_OFF_WPOS_LO, `CSPA_OFF_WPOS_HI,
			`CSPA_OFF_WMODE, `CSPA_OFF_STAT, `CSPA_OFF_FAULT, `CSPA_OFF_RPOS_LO, `CSPA_OFF_RPOS_HI,
			`CSPA_OFF_RINFO, `CSPA_OFF_ACTIVE};

		// Read data is latched in the setup cycle so prdata comes from a flop
		if (psel && !penable) begin
			unique case (paddr)
				`CSPA_OFF_CTRL:    s_nxt.prdata = {26'h0, s_r.ctrl};
				`CSPA_OFF_SEL:     s_nxt.prdata = s_r.sel;
				`CSPA_OFF_WPOS_LO: s_nxt.prdata = s_r.wpos[31:0];
				`CSPA_OFF_WPOS_HI: s_nxt.prdata = s_r.wpos[63:32];
				`CSPA_OFF_WMODE:   s_nxt.prdata = {28'h0, s_r.wmode};
				`CSPA_OFF_STAT:    s_nxt.prdata = {26'h0, s_r.wr_err, s_r.wr_busy, s_r.wr_done,
					s_r.rd_err, s_r.rd_busy, s_r.rd_valid};
				`CSPA_OFF_FAULT:   s_nxt.prdata = {s_r.wr_fault, s_r.rd_fault};
				`CSPA_OFF_RPOS_LO: s_nxt.prdata = s_r.rd_pos[31:0];
				`CSPA_OFF_RPOS_HI: s_nxt.prdata = s_r.rd_pos[63:32];
				`CSPA_OFF_RINFO:   s_nxt.prdata = {27'h0, s_r.rd_state, s_r.rd_rev, s_r.rd_fwd};
				`CSPA_OFF_ACTIVE:  s_nxt.prdata = {24'h0, s_r.active};
				default:           s_nxt.prdata = 32'h0000_0000;
			endcase
		end

		// Register writes in the access phase; read-only and unmapped ignored
		if (psel && penable && pwrite) begin
			unique case (paddr)
				`CSPA_OFF_CTRL:    s_nxt.ctrl = pwdata[5:0];
				`CSPA_OFF_SEL:     s_nxt.sel = pwdata;
				`CSPA_OFF_WPOS_LO: s_nxt.wpos[31:0] = pwdata;
				`CSPA_OFF_WPOS_HI: s_nxt.wpos[63:32] = pwdata;
				`CSPA_OFF_WMODE:   s_nxt.wmode = pwdata[3:0];
				`CSPA_OFF_ACTIVE: begin
					// Out of range profile would index past the table
					if (int'(pwdata[7:0]) < NPROF) begin
						s_nxt.active = pwdata[7:0];
					end
				end
				default: ;
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// read start edge
		s_nxt.rd_prev = s_r.ctrl[`CSPA_CTRL_RD];
		rd_go = s_r.ctrl[`CSPA_CTRL_RD] && !s_r.rd_prev && !s_r.rd_busy;
		rd_ok = (int'(s_r.rd_prof) < NPROF) && (int'(s_r.rd_pt) < NPTS) && s_r.exists[rd_fi];
		if (rd_go) begin
			s_nxt.rd_prof  = s_r.sel[`CSPA_SEL_PROF_LSB +: 8];
			s_nxt.rd_pt    = s_r.sel[`CSPA_SEL_PT_LSB +: 16];
			s_nxt.rd_busy  = 1'b1;
			s_nxt.rd_valid = 1'b0;
			s_nxt.rd_err   = 1'b0;
			s_nxt.rd_fault = `CSPA_FAULT_NONE;
		end else if (s_r.rd_busy) begin
			s_nxt.rd_busy = 1'b0;
			if (rd_ok) begin
				s_nxt.rd_valid = 1'b1;
				s_nxt.rd_pos   = pmem[rd_fi].pos;
				s_nxt.rd_fwd   = pmem[rd_fi].fwd;
				s_nxt.rd_rev   = pmem[rd_fi].rev;
				s_nxt.rd_state = s_r.pstate[rd_fi];
			end else begin
				s_nxt.rd_err   = 1'b1;
				s_nxt.rd_fault = (int'(s_r.rd_prof) >= NPROF) ? `CSPA_FAULT_PROF :
					(int'(s_r.rd_pt) >= NPTS) ? `CSPA_FAULT_POINT : `CSPA_FAULT_ABSENT;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// Pass detection over the active profile, one point per cycle
		sc_on  = (s_r.sc == SC_RUN) && s_r.exists[sc_pi];
		fhit   = sc_on && (s_r.cur_key > s_r.prev_key) && (pt_key > s_r.prev_key) && (pt_key <= s_r.cur_key);
		rhit   = sc_on && (s_r.cur_key < s_r.prev_key) && (pt_key >= s_r.cur_key) && (pt_key < s_r.prev_key);
		sc_act = fhit ? pmem[sc_pi].fwd : (rhit ? pmem[sc_pi].rev : ACT_HOLD);
		unique case (s_r.sc)
			SC_IDLE: begin
				if (master_pos_valid) begin
					s_nxt.cur_key   = new_key;
					s_nxt.prev_key  = s_r.have_prev ? s_r.cur_key : new_key;
					s_nxt.have_prev = 1'b1;
					// First sample only seeds the reference, nothing to cross yet
					if (s_r.have_prev) begin
						s_nxt.sc      = SC_RUN;
						s_nxt.sc_idx  = '0;
						s_nxt.sc_base = flat(s_r.active, 16'h0000);
					end
				end
			end
			SC_RUN: begin
				s_nxt.pstate[sc_pi] = apply_act(sc_act, s_r.pstate[sc_pi]);
				s_nxt.sc_idx = s_r.sc_idx + PW'(1);
				if (int'(s_r.sc_idx) == NPTS - 1) begin
					s_nxt.sc = SC_IDLE;
				end
			end
		endcase

		////////////////////////////////////////////////////////////////////////
		// write start edge and capture
		s_nxt.wr_prev = s_r.ctrl[`CSPA_CTRL_WR];
		wr_go = s_r.ctrl[`CSPA_CTRL_WR] && !s_r.wr_prev && !s_r.wr_busy;
		wr_ok = (int'(s_r.wr_prof) < NPROF) && (int'(s_r.wr_pt) < NPTS) &&
			(s_r.wr_op == `CSPA_WOP_ADD ? !s_r.exists[wr_fi] :
			 s_r.wr_op == `CSPA_WOP_WRITE || s_r.wr_op == `CSPA_WOP_DEL ? s_r.exists[wr_fi] : 1'b0);
		if (wr_go) begin
			s_nxt.wr_prof  = s_r.sel[`CSPA_SEL_PROF_LSB +: 8];
			s_nxt.wr_pt    = s_r.sel[`CSPA_SEL_PT_LSB +: 16];
			s_nxt.wr_pos   = s_r.wpos;
			s_nxt.wr_op    = s_r.ctrl[`CSPA_CTRL_OP_LSB +: 2];
			s_nxt.wr_fwd   = s_r.ctrl[`CSPA_CTRL_FWD_GIV] ? s_r.wmode[1:0] : ACT_HOLD;
			s_nxt.wr_rev   = s_r.ctrl[`CSPA_CTRL_REV_GIV] ? s_r.wmode[3:2] : ACT_HOLD;
			s_nxt.wr_busy  = 1'b1;
			s_nxt.wr_done  = 1'b0;
			s_nxt.wr_err   = 1'b0;
			s_nxt.wr_fault = `CSPA_FAULT_NONE;
		end else if (s_r.wr_busy) begin
			s_nxt.wr_busy = 1'b0;
			if (wr_ok) begin
				s_nxt.wr_done = 1'b1;
				if (s_r.wr_op == `CSPA_WOP_DEL) begin
					del_now = 1'b1;
					s_nxt.exists[wr_fi] = 1'b0;
					s_nxt.pstate[wr_fi] = 1'b0;
				end else begin
					mem_we = 1'b1;
					mem_wa = wr_fi;
					mem_wd = '{fwd: s_r.wr_fwd, rev: s_r.wr_rev, pos: s_r.wr_pos};
					s_nxt.exists[wr_fi] = 1'b1;
				end
			end else begin
				s_nxt.wr_err   = 1'b1;
				s_nxt.wr_fault = (int'(s_r.wr_prof) >= NPROF) ? `CSPA_FAULT_PROF :
					(int'(s_r.wr_pt) >= NPTS) ? `CSPA_FAULT_POINT :
					(s_r.wr_op == `CSPA_WOP_ADD) ? `CSPA_FAULT_EXISTS :
					(s_r.wr_op == 2'h3) ? `CSPA_FAULT_OP : `CSPA_FAULT_ABSENT;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_r        <= '0;
			s_r.ctrl   <= `CSPA_CTRL_RST;
			s_r.active <= `CSPA_ACTIVE_RST;
			s_r.sc     <= SC_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Settings memory, single write port
	always_ff @(posedge ref_clk) begin
		if (mem_we) begin
			pmem[mem_wa] <= mem_wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata              = s_r.prdata;
	assign pready              = 1'b1;
	assign pslverr             = psel && penable && !mapped;
	assign master_pos_ready    = (s_r.sc == SC_IDLE);
	assign active_point_states = s_r.pstate[int'(s_r.active) * NPTS +: NPTS];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_rd_start;
		rd_go;
	endsequence
	sequence s_rd_end;
		!s_r.rd_busy && (s_r.rd_valid != s_r.rd_err);
	endsequence

	property p_busy_excl;
		@(posedge ref_clk) disable iff (!rst_b)
		!(s_r.rd_busy && (s_r.rd_valid || s_r.rd_err)) && !(s_r.wr_busy && (s_r.wr_done || s_r.wr_err));
	endproperty
	a_busy_excl: assert property (p_busy_excl) else $error("busy overlaps done or error");

	property p_rd_flow;
		@(posedge ref_clk) disable iff (!rst_b)
		s_rd_start |=> s_r.rd_busy ##1 s_rd_end;
	endproperty
	a_rd_flow: assert property (p_rd_flow) else $error("read did not finish in two cycles");

	property p_wr_flow;
		@(posedge ref_clk) disable iff (!rst_b)
		wr_go |=> s_r.wr_busy ##1 (!s_r.wr_busy && (s_r.wr_done != s_r.wr_err));
	endproperty
	a_wr_flow: assert property (p_wr_flow) else $error("write did not finish in two cycles");

	property p_rd_info;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_r.rd_valid) |-> s_r.rd_pos == pmem[rd_fi].pos && s_r.rd_fwd == pmem[rd_fi].fwd;
	endproperty
	a_rd_info: assert property (p_rd_info) else $error("read data differs from table");

	property p_err_code;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_r.rd_err) |-> s_r.rd_fault != `CSPA_FAULT_NONE && !s_r.rd_valid;
	endproperty
	a_err_code: assert property (p_err_code) else $error("read error without code");

	property p_wr_store;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(s_r.wr_done) && s_r.wr_op != `CSPA_WOP_DEL |-> pmem[wr_fi].pos == s_r.wr_pos && s_r.exists[wr_fi];
	endproperty
	a_wr_store: assert property (p_wr_store) else $error("write not stored");

	property p_omit_mode;
		@(posedge ref_clk) disable iff (!rst_b)
		wr_go && !s_r.ctrl[`CSPA_CTRL_FWD_GIV] |=> s_r.wr_fwd == 2'h0;
	endproperty
	a_omit_mode: assert property (p_omit_mode) else $error("omitted mode not zero");

	property p_bad_keep;
		@(posedge ref_clk) disable iff (!rst_b)
		s_r.wr_busy && !wr_ok |=> s_r.wr_err && s_r.exists == $past(s_r.exists);
	endproperty
	a_bad_keep: assert property (p_bad_keep) else $error("failed write changed table");

	property p_fwd_set;
		@(posedge ref_clk) disable iff (!rst_b)
		fhit && sc_act == ACT_SET && !del_now |=> s_r.pstate[$past(sc_pi)];
	endproperty
	a_fwd_set: assert property (p_fwd_set) else $error("forward set missed");

	property p_fwd_toggle;
		@(posedge ref_clk) disable iff (!rst_b)
		fhit && sc_act == ACT_TOGGLE && !del_now |=> s_r.pstate[$past(sc_pi)] != $past(s_r.pstate[sc_pi]);
	endproperty
	a_fwd_toggle: assert property (p_fwd_toggle) else $error("forward toggle missed");

	property p_rev_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		rhit && sc_act == ACT_CLEAR |=> !s_r.pstate[$past(sc_pi)];
	endproperty
	a_rev_clear: assert property (p_rev_clear) else $error("reverse clear missed");

	property p_rev_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		rhit && sc_act == ACT_HOLD && !del_now |=> s_r.pstate[$past(sc_pi)] == $past(s_r.pstate[sc_pi]);
	endproperty
	a_rev_hold: assert property (p_rev_hold) else $error("reverse hold changed state");

endmodule // cspa_top

// file: dv/cspa_top_tb.sv
// Self-checking bench of the cam switch point block
`timescale 1ns/100ps
`include "cspa_regs.svh"

module cspa_top_tb
	import cspa_pkg::*;
;
	localparam int NPTS = 8;                  // Points per profile
	logic            ref_clk = 1'b0;          // 25 MHz clock
	logic            rst_b;                   // Sync reset, active low
	logic            psel;                    // APB select
	logic            penable;                 // APB enable
	logic            pwrite;                  // APB direction
	logic [7:0]      paddr;                   // APB address
	logic [31:0]     pwdata;                  // APB write data
	logic [31:0]     prdata;                  // APB read data
	logic            pready;                  // APB ready
	logic            pslverr;                 // APB error
	logic [63:0]     master_axis_position;    // Master position as double
	logic            master_pos_valid;        // Position strobe
	logic            master_pos_ready;        // Scanner idle
	logic [NPTS-1:0] active_point_states;     // Point states of active profile
	int              num_errors = 0;          // Mismatch count
	int              total_checks = 0;        // Comparison count

	////////////////////////////////////////////////////////////////////////
	// Clock and design
	always #20 ref_clk = ~ref_clk;

	cspa_top #(.NPROF(32), .NPTS(NPTS)) DUT (
		.ref_clk              (ref_clk),
		.rst_b                (rst_b),
		.psel                 (psel),
		.penable              (penable),
		.pwrite               (pwrite),
		.paddr                (paddr),
		.pwdata               (pwdata),
		.prdata               (prdata),
		.pready               (pready),
		.pslverr              (pslverr),
		.master_axis_position (master_axis_position),
		.master_pos_valid     (master_pos_valid),
		.master_pos_ready     (master_pos_ready),
		.active_point_states  (active_point_states)
	);

	////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge.
	// No cycle limit here: only the watchdog may end a stuck access.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		check("pslverr_wr", e, 1'b0);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check("pslverr_rd", e, 1'b0);
	endtask

	// Poll status until busy drops; b is the result bit of the command
	task automatic wait_cmd(input int b, output logic [31:0] st);
		int n;
		n = 0;
		rd(`CSPA_OFF_STAT, st);
		while (st[b+1] !== 1'b0 && n < 20) begin
			check("busy_excl", st[b] | st[b+2], 1'b0);
			n++;
			rd(`CSPA_OFF_STAT, st);
		end
		check("busy_end", st[b+1], 1'b0);
	endtask

	// Point write; ctl carries start, op and given bits
	task automatic wr_cmd(input logic [7:0] pf, input logic [15:0] pt, input real p, input logic [3:0] md,
			input logic [5:0] ctl, input logic [15:0] code);
		logic [63:0] b;
		logic [31:0] st;
		b = $realtobits(p);
		wr(`CSPA_OFF_SEL, {8'h00, pt, pf});
		wr(`CSPA_OFF_WPOS_LO, b[31:0]);
		wr(`CSPA_OFF_WPOS_HI, b[63:32]);
		wr(`CSPA_OFF_WMODE, {28'h0, md});
		wr(`CSPA_OFF_CTRL, {26'h0, ctl});
		wr(`CSPA_OFF_CTRL, 32'h0);
		wait_cmd(3, st);
		check("wr_done", st[3], code == 16'h0);
		check("wr_err", st[5], code != 16'h0);
		rd(`CSPA_OFF_FAULT, st);
		check("wr_fault", st[31:16], code);
	endtask

	// Point read; info is {state, reverse, forward}
	task automatic rd_cmd(input logic [7:0] pf, input logic [15:0] pt, input logic [15:0] code, input real p,
			input logic [4:0] info);
		logic [63:0] b;
		logic [31:0] st;
		wr(`CSPA_OFF_SEL, {8'h00, pt, pf});
		wr(`CSPA_OFF_CTRL, 32'h1);
		wr(`CSPA_OFF_CTRL, 32'h0);
		wait_cmd(0, st);
		check("rd_valid", st[0], code == 16'h0);
		check("rd_err", st[2], code != 16'h0);
		rd(`CSPA_OFF_FAULT, st);
		check("rd_fault", st[15:0], code);
		if (code == 16'h0) begin
			rd(`CSPA_OFF_RPOS_LO, st);
			b[31:0] = st;
			rd(`CSPA_OFF_RPOS_HI, st);
			b[63:32] = st;
			check("rd_pos", b, $realtobits(p));
			rd(`CSPA_OFF_RINFO, st);
			check("rd_info", st[4:0], info);
		end
	endtask

	// Hand one position sample over, wait for the scan, compare states
	task automatic send_pos(input real p, input logic [NPTS-1:0] exp);
		int n;
		n = 0;
		@(posedge ref_clk);
		master_axis_position <= $realtobits(p);
		master_pos_valid <= 1'b1;
		@(posedge ref_clk);
		while (master_pos_ready !== 1'b1 && n < 40) begin
			n++;
			@(posedge ref_clk);
		end
		master_pos_valid <= 1'b0;
		// Scrambled outside the strobe so stale sampling shows
		master_axis_position <= ~$realtobits(p);
		@(posedge ref_clk);
		while (master_pos_ready !== 1'b1 && n < 80) begin
			n++;
			@(posedge ref_clk);
		end
		check("point_states", active_point_states, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		check("states_rst", active_point_states, 8'h00);
		rd(`CSPA_OFF_STAT, q);
		check("stat_rst", q, 32'h0);
		rd(`CSPA_OFF_FAULT, q);
		check("fault_rst", q, 32'h0);
		// Unmapped address errors and reads zero
		apb(1'b0, 8'h2C, 32'h0, q, e);
		check("unmapped_err", e, 1'b1);
		check("unmapped_data", q, 32'h0);
		// Read-only and out of range writes leave no trace
		wr(`CSPA_OFF_STAT, 32'hFFFFFFFF);
		rd(`CSPA_OFF_STAT, q);
		check("stat_ro", q, 32'h0);
		wr(`CSPA_OFF_ACTIVE, 32'h28);
		rd(`CSPA_OFF_ACTIVE, q);
		check("active_rng", q, 32'h0);
	endtask

	task automatic t_cmds;
		wr_cmd(8'h00, 16'h0, 10.0, 4'h9, 6'h36, 16'h0);
		rd_cmd(8'h00, 16'h0, 16'h0, 10.0, 5'h09);
		wr_cmd(8'h00, 16'h0, 99.0, 4'h5, 6'h36, `CSPA_FAULT_EXISTS);
		wr_cmd(8'h00, 16'h1, 99.0, 4'h5, 6'h32, `CSPA_FAULT_ABSENT);
		wr_cmd(8'h20, 16'h0, 99.0, 4'h5, 6'h32, `CSPA_FAULT_PROF);
		wr_cmd(8'h00, 16'h8, 99.0, 4'h5, 6'h36, `CSPA_FAULT_POINT);
		wr_cmd(8'h00, 16'h0, 99.0, 4'h5, 6'h3E, `CSPA_FAULT_OP);
		rd_cmd(8'h00, 16'h1, `CSPA_FAULT_ABSENT, 0.0, 5'h00);
		rd_cmd(8'h1F, 16'h0, `CSPA_FAULT_ABSENT, 0.0, 5'h00);
		rd_cmd(8'h20, 16'h0, `CSPA_FAULT_PROF, 0.0, 5'h00);
		rd_cmd(8'h00, 16'h0, 16'h0, 10.0, 5'h09);
		wr_cmd(8'h00, 16'h0, 12.5, 4'hF, 6'h02, 16'h0);
		rd_cmd(8'h00, 16'h0, 16'h0, 12.5, 5'h00);
		wr_cmd(8'h00, 16'h0, -3.25, 4'h7, 6'h32, 16'h0);
		rd_cmd(8'h00, 16'h0, 16'h0, -3.25, 5'h07);
		wr_cmd(8'h00, 16'h0, 0.0, 4'h0, 6'h0A, 16'h0);
		rd_cmd(8'h00, 16'h0, `CSPA_FAULT_ABSENT, 0.0, 5'h00);
		wr_cmd(8'h00, 16'h0, 0.0, 4'h0, 6'h0A, `CSPA_FAULT_ABSENT);
	endtask

	task automatic t_pass;
		// Modes {rev,fwd}: hold/set, toggle/clear, clear/toggle, set/hold
		logic [3:0] md [4] = '{4'h1, 4'hE, 4'hB, 4'h4};
		for (int k = 0; k < 4; k++) begin
			wr_cmd(8'h01, 16'(k), 10.0 * (k + 1), md[k], 6'h36, 16'h0);
		end
		wr(`CSPA_OFF_ACTIVE, 32'h1);
		send_pos(0.0, 8'h00);
		send_pos(50.0, 8'h05);
		send_pos(0.0, 8'h0B);
		send_pos(50.0, 8'h0D);
		send_pos(45.0, 8'h0D);
		send_pos(25.0, 8'h09);
		send_pos(25.0, 8'h09);
		rd_cmd(8'h01, 16'h0, 16'h0, 10.0, 5'h11);
		// Deleting a point drops its state
		wr_cmd(8'h01, 16'h3, 0.0, 4'h0, 6'h0A, 16'h0);
		check("states_del", active_point_states, 8'h01);
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		master_axis_position = 64'h0;
		master_pos_valid = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_cmds();
		t_pass();
		report_and_stop();
	end

	// Watchdog at 20000 cycles, far beyond the several hundred cycles the run needs
	initial begin
		#(40 * 20000);
		num_errors++;
		report_and_stop();
	end
endmodule // cspa_top_tb
